// ---- hw/qot_map.svh ----
// offsets, field positions, reset values and counts of the timer channel
// assumes inclusion by bare name from the design file
`ifndef QOT_MAP_SVH
`define QOT_MAP_SVH
`define QOT_ADDR_W        2
`define QOT_ADDR_COUNT    2'h0
`define QOT_ADDR_CTRL     2'h1
`define QOT_ADDR_STATUS   2'h2
`define QOT_CTRL_START    0
`define QOT_CTRL_MODE     1
`define QOT_CTRL_X4       2
`define QOT_CTRL_FREE     3
`define QOT_CTRL_PULSE    4
`define QOT_CTRL_SRC_LO   5
`define QOT_CTRL_SRC_HI   6
`define QOT_CTRL_TRIG     7
`define QOT_CTRL_IN_DIR   8
`define QOT_CTRL_IN_DAT   9
`define QOT_CTRL_OUT_DIR  10
`define QOT_CTRL_OUT_DAT  11
`define QOT_CTRL_OS_GO    15
`define QOT_CTRL_MASK     16'h0fff
`define QOT_RST_WORD      16'h0000
`define QOT_WORD_MAX      16'hffff
`define QOT_SRC_F1        2'h0
`define QOT_SRC_F8        2'h1
`define QOT_SRC_F32       2'h2
`define QOT_SRC_SUB32     2'h3
`define QOT_DIV8_LAST     3'h7
`define QOT_DIV32_LAST    5'h1f
`endif

// ---- hw/qot_pkg.sv ----
// types shared by the timer channel
// assumes no other package
`default_nettype none
package qot_pkg;
    typedef logic [15:0] qot_word_t;
    typedef enum logic {QOT_OS_IDLE, QOT_OS_RUN} qot_os_state_t;
endpackage
`default_nettype wire

// ---- hw/qot_timer.sv ----
// 16-bit timer channel: two-phase event counter and one-shot timer
// assumes pins, trigger and subclock tick synchronous to clk_i (25 MHz)
//
// Decided for this implementation: the register addresses and the plain strobed port.
`include "qot_map.svh"
`default_nettype none
module qot_timer (
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  resetn_i,
    // register port
    input  wire logic [`QOT_ADDR_W-1:0] addr_i,
    input  wire qot_pkg::qot_word_t    wdata_i,
    input  wire logic                  we_i,
    input  wire logic                  re_i,
    output var  qot_pkg::qot_word_t    rdata_o,
    // count sources and triggers
    input  wire logic                  subclock_div32_source_i,
    input  wire logic                  timer_overflow_i,
    // channel pins
    input  wire logic                  channel_input_pin_i,
    output logic                       channel_input_pin_o,
    output logic                       channel_input_pin_oe_n_o,
    input  wire logic                  channel_output_pin_i,
    output logic                       channel_output_pin_o,
    output logic                       channel_output_pin_oe_n_o,
    // interrupt request
    output logic                       irq_o
);
    import qot_pkg::*;

    qot_word_t     counter;
    qot_word_t     reload;
    qot_word_t     ctrl;
    qot_os_state_t os_state;
    logic          in_q;
    logic          out_q;
    logic          sub_q;
    logic [4:0]    presc;
    logic          pulse_lvl;

    logic wr_count;
    logic wr_ctrl;
    logic start_f;
    logic start_now;
    logic os_mode;
    logic x4;
    logic free_run;
    logic pulse_en;
    logic trig_ovf;
    logic counting;
    logic in_edge;
    logic out_edge;
    logic up_n;
    logic dn_n;
    logic up_4;
    logic dn_4;
    logic qp_up;
    logic qp_dn;
    logic tp_wrap;
    logic tick;
    logic sw_go;
    logic ext_rise;
    logic trig;
    logic os_end;

    assign wr_count  = we_i && (addr_i == `QOT_ADDR_COUNT);
    assign wr_ctrl   = we_i && (addr_i == `QOT_ADDR_CTRL);
    assign start_f   = ctrl[`QOT_CTRL_START];
    assign start_now = wr_ctrl ? wdata_i[`QOT_CTRL_START] : start_f;
    assign os_mode   = ctrl[`QOT_CTRL_MODE];
    assign x4        = ctrl[`QOT_CTRL_X4];
    assign free_run  = ctrl[`QOT_CTRL_FREE];
    assign pulse_en  = ctrl[`QOT_CTRL_PULSE];
    assign trig_ovf  = ctrl[`QOT_CTRL_TRIG];
    assign counting  = os_mode ? (os_state == QOT_OS_RUN) : start_f;

    // two-phase decode; simultaneous edges on both pins are ambiguous
    assign in_edge  = channel_input_pin_i ^ in_q;
    assign out_edge = channel_output_pin_i ^ out_q;
    assign up_n = in_edge && channel_input_pin_i && channel_output_pin_i;
    assign dn_n = in_edge && !channel_input_pin_i && channel_output_pin_i;
    assign up_4 = (in_edge && !out_edge
                   && (channel_input_pin_i == channel_output_pin_i))
               || (out_edge && !in_edge
                   && (channel_input_pin_i != channel_output_pin_i));
    assign dn_4 = (in_edge && !out_edge
                   && (channel_input_pin_i != channel_output_pin_i))
               || (out_edge && !in_edge
                   && (channel_input_pin_i == channel_output_pin_i));
    assign qp_up = !os_mode && start_f && (x4 ? up_4 : up_n);
    assign qp_dn = !os_mode && start_f && (x4 ? dn_4 : dn_n);
    assign tp_wrap = (qp_up && (counter == `QOT_WORD_MAX))
                  || (qp_dn && (counter == `QOT_RST_WORD));

    // one-shot source and trigger
    always_comb begin
        unique case (ctrl[`QOT_CTRL_SRC_HI:`QOT_CTRL_SRC_LO])
            `QOT_SRC_F1:  tick = 1'b1;
            `QOT_SRC_F8:  tick = (presc[2:0] == `QOT_DIV8_LAST);
            `QOT_SRC_F32: tick = (presc == `QOT_DIV32_LAST);
            `QOT_SRC_SUB32: tick = subclock_div32_source_i && !sub_q;
        endcase
    end
    assign sw_go    = wr_ctrl && wdata_i[`QOT_CTRL_OS_GO];
    assign ext_rise = in_edge && channel_input_pin_i;
    assign trig = os_mode && start_now
               && (sw_go || (trig_ovf ? timer_overflow_i : ext_rise));
    assign os_end = os_mode && (os_state == QOT_OS_RUN) && tick && !trig
                 && (counter <= 16'h0001);

    // pin history and prescaler
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            in_q  <= 1'b0;
            out_q <= 1'b0;
            sub_q <= 1'b0;
            presc <= 5'h00;
        end else begin
            in_q  <= channel_input_pin_i;
            out_q <= channel_output_pin_i;
            sub_q <= subclock_div32_source_i;
            presc <= presc + 5'h01;
        end
    end

    // control register; go bit is a strobe and is not stored
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl <= `QOT_RST_WORD;
        end else if (wr_ctrl) begin
            ctrl <= wdata_i & `QOT_CTRL_MASK;
        end
    end

    // reload register
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reload <= `QOT_RST_WORD;
        end else if (wr_count) begin
            reload <= wdata_i;
        end
    end

    // counter
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            counter <= `QOT_RST_WORD;
        end else if (trig) begin
            counter <= reload;
        end else if (wr_count && !counting) begin
            counter <= wdata_i;
        end else if (qp_up) begin
            if (counter != `QOT_WORD_MAX) begin
                counter <= counter + 16'h0001;
            end else if (free_run) begin
                counter <= `QOT_RST_WORD;
            end else begin
                counter <= reload;
            end
        end else if (qp_dn) begin
            if (counter != `QOT_RST_WORD) begin
                counter <= counter - 16'h0001;
            end else if (free_run) begin
                counter <= `QOT_WORD_MAX;
            end else begin
                counter <= reload;
            end
        end else if (os_end) begin
            counter <= reload;
        end else if (os_mode && (os_state == QOT_OS_RUN) && tick) begin
            counter <= counter - 16'h0001;
        end
    end

    // one-shot run state
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            os_state <= QOT_OS_IDLE;
        end else if (!os_mode || !start_now) begin
            os_state <= QOT_OS_IDLE;
        end else if (trig) begin
            os_state <= QOT_OS_RUN;
        end else if (os_end) begin
            os_state <= QOT_OS_IDLE;
        end
    end

    // interrupt request pulse
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= tp_wrap || os_end;
        end
    end

    // pulse output level
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pulse_lvl <= 1'b0;
        end else if (pulse_en && (tp_wrap || os_end)) begin
            pulse_lvl <= !pulse_lvl;
        end
    end

    // pins: two-phase mode keeps both as inputs
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            channel_input_pin_o       <= 1'b0;
            channel_input_pin_oe_n_o  <= 1'b1;
            channel_output_pin_o      <= 1'b0;
            channel_output_pin_oe_n_o <= 1'b1;
        end else begin
            channel_input_pin_o <= ctrl[`QOT_CTRL_IN_DAT];
            channel_input_pin_oe_n_o <= !(os_mode && ctrl[`QOT_CTRL_IN_DIR]
                && trig_ovf);
            channel_output_pin_o <= pulse_en ? pulse_lvl
                                             : ctrl[`QOT_CTRL_OUT_DAT];
            channel_output_pin_oe_n_o <= !(os_mode
                && (pulse_en || ctrl[`QOT_CTRL_OUT_DIR]));
        end
    end

    // read port; one-shot count readback is not meaningful to software
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= `QOT_RST_WORD;
        end else if (re_i) begin
            unique case (addr_i)
                `QOT_ADDR_COUNT:  rdata_o <= counter;
                `QOT_ADDR_CTRL:   rdata_o <= ctrl;
                `QOT_ADDR_STATUS: rdata_o <= {12'h000, pulse_lvl,
                    channel_output_pin_i, channel_input_pin_i, counting};
                default:          rdata_o <= `QOT_RST_WORD;
            endcase
        end else begin
            rdata_o <= `QOT_RST_WORD;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    // two-phase counting, interrupt request, readback and stopped writes
    AST_TP_PINS_IN: assert property (!os_mode |=>
        (channel_input_pin_oe_n_o && channel_output_pin_oe_n_o))
        else $error("pin driven in two-phase mode");

    AST_UP_RELOAD: assert property (
        (qp_up && !trig && !(wr_count && !counting) && !free_run
         && counter == `QOT_WORD_MAX) |=> counter == $past(reload))
        else $error("no reload on overflow");

    AST_DN_RELOAD: assert property (
        (qp_dn && !free_run && counter == `QOT_RST_WORD)
        |=> counter == $past(reload))
        else $error("no reload on underflow");

    AST_FREE_WRAP: assert property (
        (qp_dn && !trig && !(wr_count && !counting) && free_run
         && counter == `QOT_RST_WORD) |=> counter == `QOT_WORD_MAX)
        else $error("free run did not wrap");

    AST_FREE_UP: assert property (
        (qp_up && free_run && counter == `QOT_WORD_MAX)
        |=> counter == `QOT_RST_WORD)
        else $error("free run did not wrap up");

    AST_DN_STEP: assert property (
        (qp_dn && !(wr_count && !counting) && counter != `QOT_RST_WORD)
        |=> counter == $past(counter) - 16'h0001)
        else $error("down count step wrong");

    AST_UP_STEP: assert property (
        (qp_up && counter != `QOT_WORD_MAX)
        |=> counter == $past(counter) + 16'h0001)
        else $error("up count step wrong");

    AST_HALT: assert property (
        (!os_mode && !start_f && !wr_count && !trig)
        |=> counter == $past(counter))
        else $error("counter moved while halted");

    AST_NORMAL_ONLY_IN: assert property (
        (!os_mode && start_f && !x4 && !(in_edge && channel_output_pin_i))
        |=> counter == $past(counter))
        else $error("normal mode counted without input edge");

    AST_X4_UP: assert property (
        (!os_mode && start_f && x4 && up_4 && counter != `QOT_WORD_MAX)
        |=> counter == $past(counter) + 16'h0001)
        else $error("times four up step wrong");

    AST_X4_DN: assert property (
        (!os_mode && start_f && x4 && dn_4 && counter != `QOT_RST_WORD)
        |=> counter == $past(counter) - 16'h0001)
        else $error("times four down step wrong");

    AST_X4_BOTH: assert property (
        (!os_mode && start_f && x4 && in_edge && out_edge)
        |=> counter == $past(counter))
        else $error("counted on simultaneous pin edges");

    AST_IRQ: assert property (
        (tp_wrap || os_end) |=> irq_o
        ##1 (!irq_o || $past(tp_wrap || os_end)))
        else $error("interrupt request timing wrong");

    AST_IRQ_CAUSE: assert property (
        !(tp_wrap || os_end) |=> !irq_o)
        else $error("spurious interrupt request");

    AST_READ: assert property (
        (re_i && addr_i == `QOT_ADDR_COUNT) |=> rdata_o == $past(counter))
        else $error("count readback wrong");

    AST_READ_IDLE: assert property (
        !re_i |=> rdata_o == `QOT_RST_WORD)
        else $error("read data outside read cycle");

    AST_WR_STOP: assert property (
        (wr_count && !counting && !trig)
        |=> (counter == $past(wdata_i)) && (reload == $past(wdata_i)))
        else $error("stopped write missed counter");

    // one-shot
    AST_OS_END: assert property (os_end |=>
        (os_state == QOT_OS_IDLE) && irq_o && counter == $past(reload))
        else $error("one-shot end wrong");

    AST_OS_TICK: assert property (
        (os_mode && os_state == QOT_OS_RUN && tick && !trig
         && counter > 16'h0001) |=> counter == $past(counter) - 16'h0001)
        else $error("one-shot tick step wrong");

    AST_OS_HOLD: assert property (
        (os_mode && os_state == QOT_OS_RUN && !tick && !trig)
        |=> counter == $past(counter))
        else $error("one-shot moved without tick");

    AST_RETRIG: assert property (trig |=>
        (os_state == QOT_OS_RUN) && counter == $past(reload))
        else $error("retrigger did not reload");

    AST_GO: assert property (
        (os_mode && wr_ctrl && wdata_i[`QOT_CTRL_START]
         && wdata_i[`QOT_CTRL_OS_GO]) |=> os_state == QOT_OS_RUN)
        else $error("software go did not start");

    AST_STOP: assert property (
        (wr_ctrl && !wdata_i[`QOT_CTRL_START]) |=> os_state == QOT_OS_IDLE)
        else $error("clearing start did not stop");

    // pins and pulse output
    AST_OS_OUT_PIN: assert property (
        (os_mode && ctrl[`QOT_CTRL_OUT_DIR]) |=> !channel_output_pin_oe_n_o)
        else $error("output pin not driven");

    AST_OS_IN_PIN: assert property (
        (os_mode && trig_ovf && ctrl[`QOT_CTRL_IN_DIR])
        |=> !channel_input_pin_oe_n_o)
        else $error("input pin not driven");

    AST_PULSE: assert property (
        (pulse_en && (tp_wrap || os_end)) |=> pulse_lvl != $past(pulse_lvl))
        else $error("pulse level did not invert");
endmodule
`default_nettype wire

// ---- tb/qot_encoder.sv ----
// two-phase encoder and trigger pulse source on the channel pins
// assumes the bench calls its tasks; pins change right after a rising edge
`default_nettype none
module qot_encoder (
    // clock
    input  wire logic clk_i,
    // pin levels
    output var  logic in_o,
    output var  logic out_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        in_o = 1'b0;
        out_o = 1'b0;
    end
    // one full period; a pin moves every second edge, never both at once
    task automatic step(input bit up);
        logic [7:0] seq;
        seq = up ? 8'h78 : 8'hb4;
        for (int i = 0; i < 4; i++) begin
            repeat (2) @(posedge clk_i);
            {in_o, out_o} <= seq[7-2*i -: 2];
        end
    endtask
    // rising edge on the input-side pin, used as a one-shot trigger
    task automatic pulse_in();
        @(posedge clk_i);
        in_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        in_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the timer channel
// assumes qot_pkg compiled first; encoder model drives the pins
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import qot_pkg::*;
    logic       clk = 1'b0, resetn = 1'b0, we = 1'b0, re = 1'b0;
    logic       sub = 1'b0, ovf = 1'b0;
    logic [1:0] addr = 2'h0;
    qot_word_t  wdata = 16'h0000, rdata, d;
    logic       enc_in, enc_out, in_o, in_oe_n, out_o, out_oe_n, irq;
    logic       in_w, out_w;
    int         num_errors = 0, total_checks = 0, irqs = 0, k;
    // pin level: design drive wins only while it enables its driver
    assign in_w = in_oe_n ? enc_in : in_o;
    assign out_w = out_oe_n ? enc_out : out_o;
    always #20 clk = ~clk;
    always begin
        repeat (4) @(posedge clk);
        sub <= ~sub;
    end
    always @(posedge clk) if (irq === 1'b1) irqs <= irqs + 1;
    qot_encoder qot_encoder_inst (.clk_i(clk), .in_o(enc_in),
        .out_o(enc_out));
    qot_timer qot_timer_inst (.clk_i(clk), .resetn_i(resetn),
        .addr_i(addr), .wdata_i(wdata), .we_i(we), .re_i(re),
        .rdata_o(rdata), .subclock_div32_source_i(sub),
        .timer_overflow_i(ovf), .channel_input_pin_i(in_w),
        .channel_input_pin_o(in_o), .channel_input_pin_oe_n_o(in_oe_n),
        .channel_output_pin_i(out_w), .channel_output_pin_o(out_o),
        .channel_output_pin_oe_n_o(out_oe_n), .irq_o(irq));
    task automatic close_out();
        if (num_errors == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input qot_word_t e, qot_word_t g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [1:0] a, input qot_word_t v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, output qot_word_t v);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 v = rdata;
    endtask
    // cycles until the interrupt pulse, bounded
    task automatic wirq(input int lim, output int n);
        n = 0;
        while (irq !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1 n++;
        end
    endtask
    task automatic run_is(input qot_word_t e);
        rd(2'h2, d);
        chk("running", e, d & 16'h0001);
    endtask
    initial begin
        #400000 num_errors++;
        close_out();
    end
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(2'h1, d);
        chk("ctrl reset", 16'h0000, d);
        wr(2'h3, 16'hffff);
        rd(2'h3, d);
        chk("unmapped", 16'h0000, d);
        wr(2'h0, 16'hfffd);
        rd(2'h0, d);
        chk("count stopped", 16'hfffd, d);
        wr(2'h1, 16'h0001);
        wr(2'h0, 16'h0010);
        rd(2'h0, d);
        chk("count running", 16'hfffd, d);
        chk("pins undriven", 16'h0003, {14'h0, in_oe_n, out_oe_n});
        repeat (3) qot_encoder_inst.step(1'b1);
        rd(2'h0, d);
        chk("up wrap reload", 16'h0010, d);
        chk("up wrap irq", 16'h0001, 16'(irqs));
        qot_encoder_inst.step(1'b0);
        rd(2'h0, d);
        chk("normal down", 16'h000f, d);
        wr(2'h1, 16'h0000);
        wr(2'h0, 16'h0001);
        wr(2'h1, 16'h000d);
        qot_encoder_inst.step(1'b0);
        rd(2'h0, d);
        chk("x4 down free", 16'hfffd, d);
        chk("free wrap irq", 16'h0002, 16'(irqs));
        qot_encoder_inst.step(1'b1);
        rd(2'h0, d);
        chk("x4 up", 16'h0001, d);
        wr(2'h1, 16'h000c);
        qot_encoder_inst.step(1'b1);
        rd(2'h0, d);
        chk("halted", 16'h0001, d);
        // software go, f1 source, three ticks
        wr(2'h0, 16'h0003);
        // mode first: go only counts once one-shot mode stands
        wr(2'h1, 16'h0412);
        wr(2'h1, 16'h8413);
        wirq(50, k);
        chk("one-shot period", 16'h0003, 16'(k));
        run_is(16'h0000);
        chk("pulse out", 16'h0001, {15'h0, out_o});
        chk("out driven", 16'h0000, {15'h0, out_oe_n});
        chk("zero irq", 16'h0004, 16'(irqs));
        // timer overflow trigger, /8 source, retrigger midway
        wr(2'h0, 16'h0002);
        wr(2'h1, 16'h03a3);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk) ovf <= 1'b1;
            @(posedge clk) ovf <= 1'b0;
            repeat (4) @(posedge clk);
        end
        chk("in driven", 16'h0001, {14'h0, in_oe_n, in_o});
        run_is(16'h0001);
        wirq(40, k);
        chk("retrig irq", 16'h0009, 16'(k));
        // pin trigger on subclock source, then software stop
        wr(2'h0, 16'h0005);
        wr(2'h1, 16'h0063);
        // released input pin falls first, so the pulse is a clean rise
        repeat (2) @(posedge clk);
        qot_encoder_inst.pulse_in();
        repeat (4) @(posedge clk);
        run_is(16'h0001);
        wr(2'h1, 16'h0062);
        run_is(16'h0000);
        repeat (100) @(posedge clk);
        chk("no irq after stop", 16'h0005, 16'(irqs));
        // /32 source, software go, two ticks
        wr(2'h0, 16'h0002);
        wr(2'h1, 16'h8043);
        wirq(50, k);
        chk("div32 period", 16'h0024, 16'(k));
        close_out();
    end
endmodule
`default_nettype wire
